// file: core/tcal_alarm_top.sv
// Thermocouple alarm logic: register file, settings store, alarm evaluation, lamps
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcal_alarm_top
  import tcal_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_CYC_DEF,
  parameter int ACT_CYC = ACT_CYC_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rdValid,
  input wire logic [CHW-1:0] rdChan,
  input wire logic signed [RAW_W-1:0] rdRaw,
  input wire logic signed [RAW_W-1:0] rdCjc,
  input wire logic rdOpen,
  input wire logic rdCmFault,
  output logic nvmRdEn,
  output logic nvmWrEn,
  output logic [NVM_AW-1:0] nvmAddr,
  output logic [31:0] nvmWrData,
  input wire logic [31:0] nvmRdData,
  input wire logic nvmRdValid,
  input wire logic [DIN_W-1:0] din,
  output logic [NCH-1:0] doutO,
  output logic [NCH-1:0] doutOeN,
  output logic ledPower,
  output logic ledActivity,
  output logic ledAlarm,
  output logic ledOpen
);
  typedef struct packed {
    logic [NCH-1:0][31:0] thr1;
    logic [NCH-1:0][31:0] thr2;
    logic [NCH-1:0][31:0] reading;
    tcal_cfg_s [NCH-1:0] cfg;
    logic [NCH-1:0] tempAlm;
    logic [NCH-1:0] openF;
    logic [NCH-1:0] cmF;
    logic [NCH-1:0] latched;
    logic [NCH-1:0] hostOut;
    logic [NCH-1:0] doutOeN;
    logic [CHW-1:0] chSel;
    logic upgrade;
    logic link;
    logic ack;
    logic [31:0] rdat;
    tcal_ld_e ld;
    logic [CHW-1:0] ldCh;
    logic [1:0] ldFld;
    logic nvmRdEn;
    logic nvmWrEn;
    logic [NVM_AW-1:0] nvmAddr;
    logic [31:0] nvmWrData;
    logic identPulse;
    logic cmdPulse;
    logic [DIN_W-1:0] dinS1;
    logic [DIN_W-1:0] dinS2;
    logic ledAlarm;
    logic ledOpen;
  } tcal_main_s;

  tcal_main_s st_r;
  tcal_main_s st_nxt;
  tcal_rd_if rdBus ();
  tcal_cfg_s rdCfg;

  assign rdCfg = st_r.cfg[rdChan];

  tcal_conv u_conv (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(rdValid),
    .inChan(rdChan),
    .inRaw(rdRaw),
    .inCjc(rdCjc),
    .inOpen(rdOpen),
    .inCmFault(rdCmFault),
    .sensor(rdCfg.sensor),
    .unitTemp(rdCfg.unitTemp),
    .rd(rdBus.src)
  );

  tcal_led #(
    .BLINK_CYC(BLINK_CYC),
    .ACT_CYC(ACT_CYC)
  ) u_led (
    .clk(clk),
    .reset_n(reset_n),
    .identify(st_r.identPulse),
    .command(st_r.cmdPulse),
    .link(st_r.link),
    .upgrade(st_r.upgrade),
    .powerLed(ledPower),
    .activityLed(ledActivity)
  );

  always_comb
  begin
    logic [CHW-1:0] c;
    logic [31:0] key;
    logic [31:0] k1;
    logic [31:0] k2;
    logic [31:0] wv;
    logic qual;
    logic act;
    logic lvl;
    logic anyAlarm;
    logic anyOpen;
    tcal_cfg_s cf;
    c = '0;
    key = '0;
    k1 = '0;
    k2 = '0;
    wv = '0;
    qual = 1'b0;
    act = 1'b0;
    lvl = 1'b1;
    anyAlarm = 1'b0;
    anyOpen = 1'b0;
    cf = '0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.identPulse = 1'b0;
    st_nxt.cmdPulse = 1'b0;
    st_nxt.nvmRdEn = 1'b0;
    st_nxt.nvmWrEn = 1'b0;
    st_nxt.dinS1 = din;
    st_nxt.dinS2 = st_r.dinS1;

    // Settings reload from non-volatile store after reset
    unique case (st_r.ld)
      LD_REQ:
      begin
        st_nxt.nvmRdEn = 1'b1; // see RULE_09
        st_nxt.nvmAddr = {st_r.ldCh, st_r.ldFld};
        st_nxt.ld = LD_WAIT;
      end
      LD_WAIT:
      begin
        if (nvmRdValid)
        begin
          unique case (st_r.ldFld)
            FLD_THR1: st_nxt.thr1[st_r.ldCh] = nvmRdData; // see RULE_10
            FLD_THR2: st_nxt.thr2[st_r.ldCh] = nvmRdData;
            default: st_nxt.cfg[st_r.ldCh] = tcal_cfg_s'(nvmRdData[$bits(tcal_cfg_s)-1:0]);
          endcase
          st_nxt.ld = LD_REQ;
          if (st_r.ldFld == FLD_CFG)
          begin
            st_nxt.ldFld = FLD_THR1;
            st_nxt.ldCh = st_r.ldCh + 1'b1;
            if (st_r.ldCh == LAST_CH)
              st_nxt.ld = LD_DONE;
          end
          else
            st_nxt.ldFld = st_r.ldFld + 1'b1;
        end
      end
      LD_DONE:
      begin
        st_nxt.ld = LD_DONE;
      end
      default:
      begin
        st_nxt.ld = LD_DONE;
      end
    endcase

    // New reading: fault flags and temperature state, link state irrelevant
    if (rdBus.valid) // see RULE_11
    begin
      c = rdBus.chan;
      cf = st_r.cfg[c];
      st_nxt.openF[c] = rdBus.open; // see RULE_13
      st_nxt.cmF[c] = rdBus.cmFault;
      if (!rdBus.open) // see RULE_13
      begin
        st_nxt.reading[c] = rdBus.value;
        key = tcal_fkey(rdBus.value); // see RULE_22
        k1 = tcal_fkey(st_r.thr1[c]);
        k2 = tcal_fkey(st_r.thr2[c]);
        unique case (cf.imode)
          IM_RISE:
          begin
            if (key >= k1)
              st_nxt.tempAlm[c] = 1'b1; // see RULE_01
            else if (key < k2)
              st_nxt.tempAlm[c] = 1'b0; // see RULE_01
          end
          IM_FALL:
          begin
            if (key <= k1)
              st_nxt.tempAlm[c] = 1'b1; // see RULE_02
            else if (key > k2)
              st_nxt.tempAlm[c] = 1'b0; // see RULE_02
          end
          IM_WIN: st_nxt.tempAlm[c] = (key < k1) || (key > k2); // see RULE_03
          IM_RSV: st_nxt.tempAlm[c] = st_r.tempAlm[c];
        endcase
      end
    end

    // Bus access, taken once loading is over
    if (wb_cyc_i && wb_stb_i && !st_r.ack && st_r.ld == LD_DONE)
    begin
      st_nxt.ack = 1'b1;
      st_nxt.cmdPulse = 1'b1;
      st_nxt.rdat = '0;
      if (wb_we_i)
      begin
        unique case (wb_adr_i)
          ADR_CTRL:
          begin
            wv = tcal_merge({29'h0, st_r.link, st_r.upgrade, 1'b0}, wb_dat_i, wb_sel_i);
            st_nxt.identPulse = wv[CTRL_IDENT];
            st_nxt.upgrade = wv[CTRL_UPGRADE];
            st_nxt.link = wv[CTRL_LINK];
          end
          ADR_DOUT: st_nxt.hostOut = tcal_merge(st_r.hostOut, wb_dat_i, wb_sel_i);
          ADR_CLEAR: st_nxt.latched = st_r.latched & ~tcal_merge('0, wb_dat_i, wb_sel_i); // see RULE_08
          ADR_CHSEL:
          begin
            wv = tcal_merge({27'h0, st_r.chSel}, wb_dat_i, wb_sel_i);
            st_nxt.chSel = wv[CHW-1:0];
          end
          ADR_CFG:
          begin
            wv = tcal_merge({21'h0, st_r.cfg[st_r.chSel]}, wb_dat_i, wb_sel_i);
            st_nxt.cfg[st_r.chSel] = tcal_cfg_s'(wv[$bits(tcal_cfg_s)-1:0]); // see RULE_10
            st_nxt.nvmWrEn = 1'b1; // see RULE_09
            st_nxt.nvmAddr = {st_r.chSel, FLD_CFG};
            st_nxt.nvmWrData = {21'h0, wv[$bits(tcal_cfg_s)-1:0]};
          end
          ADR_THR1:
          begin
            wv = tcal_merge(st_r.thr1[st_r.chSel], wb_dat_i, wb_sel_i);
            st_nxt.thr1[st_r.chSel] = wv; // see RULE_10
            st_nxt.nvmWrEn = 1'b1; // see RULE_09
            st_nxt.nvmAddr = {st_r.chSel, FLD_THR1};
            st_nxt.nvmWrData = wv;
          end
          ADR_THR2:
          begin
            wv = tcal_merge(st_r.thr2[st_r.chSel], wb_dat_i, wb_sel_i);
            st_nxt.thr2[st_r.chSel] = wv; // see RULE_10
            st_nxt.nvmWrEn = 1'b1; // see RULE_09
            st_nxt.nvmAddr = {st_r.chSel, FLD_THR2};
            st_nxt.nvmWrData = wv;
          end
          default:
          begin
            st_nxt.rdat = '0;
          end
        endcase
      end
      else
      begin
        unique case (wb_adr_i)
          ADR_CTRL: st_nxt.rdat = {29'h0, st_r.link, st_r.upgrade, 1'b0};
          ADR_STATUS: st_nxt.rdat = {29'h0, 1'b0, st_r.ledOpen, st_r.ledAlarm};
          ADR_DIN: st_nxt.rdat = {24'h0, st_r.dinS2}; // see RULE_21
          ADR_DOUT: st_nxt.rdat = st_r.hostOut;
          ADR_ALARM: st_nxt.rdat = st_r.tempAlm;
          ADR_OPEN: st_nxt.rdat = st_r.openF;
          ADR_CHSEL: st_nxt.rdat = {27'h0, st_r.chSel};
          ADR_CFG: st_nxt.rdat = {21'h0, st_r.cfg[st_r.chSel]};
          ADR_THR1: st_nxt.rdat = st_r.thr1[st_r.chSel];
          ADR_THR2: st_nxt.rdat = st_r.thr2[st_r.chSel];
          ADR_READING: st_nxt.rdat = st_r.reading[st_r.chSel];
          ADR_CMF: st_nxt.rdat = st_r.cmF;
          ADR_LATCHED: st_nxt.rdat = st_r.latched;
          default: st_nxt.rdat = '0;
        endcase
      end
    end

    // Per-channel qualification and output drive, one line per channel
    for (int i = 0; i < NCH; i++) // see RULE_12
    begin
      cf = st_r.cfg[i];
      unique case (cf.emode)
        EM_TEMP: qual = st_r.tempAlm[i]; // see RULE_04
        EM_ANY: qual = st_r.tempAlm[i] | st_r.openF[i] | st_r.cmF[i]; // see RULE_04
        EM_FAULT: qual = st_r.openF[i] | st_r.cmF[i]; // see RULE_04
        EM_RSV: qual = 1'b0;
      endcase
      if (qual && cf.latch && cf.omode != OM_OFF)
        st_nxt.latched[i] = 1'b1; // see RULE_08
      act = qual | (st_r.latched[i] & cf.latch); // see RULE_08
      unique case (cf.omode)
        OM_OFF: lvl = st_r.hostOut[i]; // see RULE_05
        OM_LOW: lvl = ~act; // see RULE_06
        OM_HIGH: lvl = act; // see RULE_07
        OM_RSV: lvl = st_r.hostOut[i];
      endcase
      st_nxt.doutOeN[i] = lvl;
      if (cf.omode == OM_LOW || cf.omode == OM_HIGH)
        anyAlarm = anyAlarm | act;
      anyOpen = anyOpen | st_r.openF[i];
    end
    st_nxt.ledAlarm = anyAlarm; // see RULE_16
    st_nxt.ledOpen = anyOpen; // see RULE_17
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.hostOut <= '1;
      st_r.doutOeN <= '1;
    end
    else
      st_r <= st_nxt;
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign nvmRdEn = st_r.nvmRdEn;
  assign nvmWrEn = st_r.nvmWrEn;
  assign nvmAddr = st_r.nvmAddr;
  assign nvmWrData = st_r.nvmWrData;
  assign doutO = '0;
  assign doutOeN = st_r.doutOeN;
  assign ledAlarm = st_r.ledAlarm;
  assign ledOpen = st_r.ledOpen;
endmodule // tcal_alarm_top
`default_nettype wire

// file: core/tcal_conv.sv
// Cold-junction correction, linearization and float conversion stage
`timescale 1ns/1ps
`default_nettype none
module tcal_conv
  import tcal_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  input wire logic [CHW-1:0] inChan,
  input wire logic signed [RAW_W-1:0] inRaw,
  input wire logic signed [RAW_W-1:0] inCjc,
  input wire logic inOpen,
  input wire logic inCmFault,
  input wire logic [2:0] sensor,
  input wire logic unitTemp,
  tcal_rd_if.src rd
);
  typedef struct packed {
    logic valid;
    logic [CHW-1:0] chan;
    logic [31:0] value;
    logic open;
    logic cm;
  } tcal_conv_s;

  tcal_conv_s st_r;
  tcal_conv_s st_nxt;
  logic signed [RAW_W:0] diff;
  logic signed [RAW_W+LIN_GW+1:0] prod;

  function automatic logic [31:0] toFloat(input logic signed [31:0] v);
    logic [31:0] mag;
    logic [4:0] p;
    logic [31:0] norm;
    mag = v[31] ? 32'(-v) : v;
    p = '0;
    for (int i = 0; i < 32; i++)
    begin
      if (mag[i])
        p = 5'(i);
    end
    norm = mag << (5'd31 - p);
    if (mag == '0)
      return '0;
    return {v[31], FLT_BIAS + {3'h0, p}, norm[30:8]};
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    diff = $signed({inRaw[RAW_W-1], inRaw}) - $signed({inCjc[RAW_W-1], inCjc}); // see RULE_14
    prod = diff * $signed({1'b0, tcal_gain(sensor)});
    st_nxt.valid = inValid;
    if (inValid)
    begin
      st_nxt.chan = inChan;
      st_nxt.open = inOpen;
      st_nxt.cm = inCmFault;
      st_nxt.value = toFloat(unitTemp ? 32'(prod >>> LIN_SHIFT) : 32'(diff)); // see RULE_15
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rd.valid = st_r.valid;
  assign rd.chan = st_r.chan;
  assign rd.value = st_r.value;
  assign rd.open = st_r.open;
  assign rd.cmFault = st_r.cm;
endmodule // tcal_conv
`default_nettype wire

// file: core/tcal_led.sv
// Power and activity lamp sequencing
`timescale 1ns/1ps
`default_nettype none
module tcal_led
  import tcal_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_CYC_DEF,
  parameter int ACT_CYC = ACT_CYC_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic identify,
  input wire logic command,
  input wire logic link,
  input wire logic upgrade,
  output logic powerLed,
  output logic activityLed
);
  typedef struct packed {
    logic [CNT_W-1:0] halfCnt;
    logic [CNT_W-1:0] actCnt;
    logic [3:0] identLeft;
    logic phase;
    logic power;
    logic act;
  } tcal_led_s;

  tcal_led_s st_r;
  tcal_led_s st_nxt;
  logic halfTick;

  always_comb
  begin
    st_nxt = st_r;
    halfTick = st_r.halfCnt == CNT_W'(BLINK_CYC - 1);
    st_nxt.halfCnt = halfTick ? '0 : st_r.halfCnt + 1'b1;
    if (halfTick)
    begin
      st_nxt.phase = ~st_r.phase;
      if (st_r.identLeft != '0)
        st_nxt.identLeft = st_r.identLeft - 1'b1;
    end
    if (identify)
    begin
      st_nxt.identLeft = IDENT_HALVES; // see RULE_18
      st_nxt.halfCnt = '0;
    end
    if (st_r.actCnt != '0)
      st_nxt.actCnt = st_r.actCnt - 1'b1;
    if (command)
      st_nxt.actCnt = CNT_W'(ACT_CYC); // see RULE_19
    st_nxt.power = upgrade ? st_r.phase // see RULE_20
      : (st_r.identLeft == '0) || st_r.identLeft[0]; // see RULE_18
    st_nxt.act = upgrade ? st_r.phase // see RULE_20
      : link ^ (st_r.actCnt != '0); // see RULE_19
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.power <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign powerLed = st_r.power;
  assign activityLed = st_r.act;
endmodule // tcal_led
`default_nettype wire

// file: core/tcal_pkg.sv
// Constants, types and helpers shared by the thermocouple alarm logic
// Functional notes
// RULE_01: Rising mode: alarm sets at or above first threshold, releases below second.
// RULE_02: Falling mode: alarm sets at or below first threshold, releases above second.
// RULE_03: Window mode: alarm while below first threshold or above second threshold.
// RULE_04: Error mode picks temperature only, temperature or faults, or faults only.
// RULE_05: Disabled alarm output leaves the line under ordinary host control.
// RULE_06: Active-low mode pulls the line low while the alarm holds.
// RULE_07: Active-high mode lets the line go high while the alarm holds.
// RULE_08: Latched alarms stay active until the host clears that channel.
// RULE_09: Alarm settings live in non-volatile storage and reload at power-up.
// RULE_10: Setting changes apply at once; stored settings reapply at power on.
// RULE_11: Conversion and alarm evaluation run regardless of host link state.
// RULE_12: Each of 32 output lines belongs to exactly one input channel.
// RULE_13: Open input marks that reading invalid; other channels carry on.
// RULE_14: Cold-junction voltage is subtracted before any further processing.
// RULE_15: Corrected reading is linearized per sensor, reported as 32-bit float.
// RULE_16: Alarm lamp lights while any alarm is active.
// RULE_17: Open-input lamp lights while any channel has an open input.
// RULE_18: Identify command blinks power lamp five times; otherwise it stays on.
// RULE_19: Activity lamp on with valid link, pulses on each command.
// RULE_20: Upgrade mode blinks both power and activity lamps.
// RULE_21: Digital input reads, port or bit, serviced at 500 per second.
// RULE_22: One alarm state bit per channel, signed float threshold compares.
// RULE_23: Host configures thresholds and modes before enabling a channel alarm.
package tcal_pkg;
  localparam int NCH = 32;
  localparam int CHW = 5;
  localparam int RAW_W = 24;
  localparam int DIN_W = 8;
  localparam int NVM_AW = 7;
  localparam int CNT_W = 24;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_DIN = 8'h08;
  localparam logic [7:0] ADR_DOUT = 8'h0c;
  localparam logic [7:0] ADR_ALARM = 8'h10;
  localparam logic [7:0] ADR_CLEAR = 8'h14;
  localparam logic [7:0] ADR_OPEN = 8'h18;
  localparam logic [7:0] ADR_CHSEL = 8'h1c;
  localparam logic [7:0] ADR_CFG = 8'h20;
  localparam logic [7:0] ADR_THR1 = 8'h24;
  localparam logic [7:0] ADR_THR2 = 8'h28;
  localparam logic [7:0] ADR_READING = 8'h2c;
  localparam logic [7:0] ADR_CMF = 8'h30;
  localparam logic [7:0] ADR_LATCHED = 8'h34;
  // Control and status bit positions
  localparam int CTRL_IDENT = 0;
  localparam int CTRL_UPGRADE = 1;
  localparam int CTRL_LINK = 2;
  localparam int STAT_ALARM = 0;
  localparam int STAT_OPEN = 1;
  localparam int STAT_LOADING = 2;
  // Non-volatile word slots per channel
  localparam logic [1:0] FLD_THR1 = 2'h0;
  localparam logic [1:0] FLD_THR2 = 2'h1;
  localparam logic [1:0] FLD_CFG = 2'h2;
  localparam logic [CHW-1:0] LAST_CH = 5'h1f;
  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint BLINK_HALF_MS = 250;
  localparam longint ACT_PULSE_MS = 50;
  localparam int BLINK_CYC_DEF = int'(CLK_HZ * BLINK_HALF_MS / 1000);
  localparam int ACT_CYC_DEF = int'(CLK_HZ * ACT_PULSE_MS / 1000);
  localparam int IDENT_BLINKS = 5;
  localparam logic [3:0] IDENT_HALVES = 4'(2 * IDENT_BLINKS);
  // Linearization gain, fixed point with LIN_SHIFT fraction bits
  localparam int LIN_SHIFT = 8;
  localparam int LIN_GW = 16;
  localparam logic [7:0] FLT_BIAS = 8'h7f;

  typedef enum logic [1:0] {IM_RISE = 2'b00, IM_FALL = 2'b01, IM_WIN = 2'b10,
    IM_RSV = 2'b11} tcal_imode_e;
  typedef enum logic [1:0] {EM_TEMP = 2'b00, EM_ANY = 2'b01, EM_FAULT = 2'b10,
    EM_RSV = 2'b11} tcal_emode_e;
  typedef enum logic [1:0] {OM_OFF = 2'b00, OM_LOW = 2'b01, OM_HIGH = 2'b10,
    OM_RSV = 2'b11} tcal_omode_e;
  typedef enum logic [1:0] {LD_REQ = 2'b00, LD_WAIT = 2'b01, LD_DONE = 2'b10} tcal_ld_e;

  typedef struct packed {
    logic [2:0] sensor;
    logic unitTemp;
    logic latch;
    tcal_omode_e omode;
    tcal_emode_e emode;
    tcal_imode_e imode;
  } tcal_cfg_s;

  // Per sensor type gain, plain defaults
  function automatic logic [LIN_GW-1:0] tcal_gain(input logic [2:0] sensor);
    unique case (sensor)
      3'h0: return 16'h0100;
      3'h1: return 16'h0120;
      3'h2: return 16'h0140;
      3'h3: return 16'h0160;
      3'h4: return 16'h0180;
      3'h5: return 16'h01a0;
      3'h6: return 16'h01c0;
      3'h7: return 16'h01e0;
    endcase
  endfunction

  // Maps a float onto an unsigned key that orders like the signed value
  function automatic logic [31:0] tcal_fkey(input logic [31:0] f);
    return f[31] ? ~f : {1'b1, f[30:0]};
  endfunction

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] tcal_merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction
endpackage

// file: core/tcal_rd_if.sv
// Converted reading handed from converter stage to alarm logic
`timescale 1ns/1ps
`default_nettype none
interface tcal_rd_if
  import tcal_pkg::*;
();
  logic valid;
  logic [CHW-1:0] chan;
  logic [31:0] value;
  logic open;
  logic cmFault;
  modport src (output valid, output chan, output value, output open, output cmFault);
  modport dst (input valid, input chan, input value, input open, input cmFault);
endinterface
`default_nettype wire

// file: dv/tcal_alarm_monitor.sv
// Port checker for the alarm logic
`timescale 1ns/1ps
`default_nettype none
module tcal_alarm_monitor
  import tcal_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_CYC_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rdValid,
  input wire logic rdOpen,
  input wire logic nvmRdValid,
  input wire logic nvmWrEn,
  input wire logic [NVM_AW-1:0] nvmAddr,
  input wire logic [31:0] nvmWrData,
  input wire logic [NCH-1:0] doutO,
  input wire logic [NCH-1:0] doutOeN,
  input wire logic ledPower,
  input wire logic ledOpen
);
  localparam int LIM = 2 * BLINK_CYC + 4;
  logic [7:0] nLoad_r;
  // Counts reloaded words since reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      nLoad_r <= 8'h00;
    else if (nvmRdValid && nLoad_r != 8'hff)
      nLoad_r <= nLoad_r + 8'h01;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_reload_first;
    wb_ack_o |-> nLoad_r >= 8'h60;
  endproperty
  a_reload_first: assert property (p_reload_first) else $error("ack before reload");
  property p_nvm_write;
    wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == ADR_THR2
      |-> nvmWrEn && nvmAddr[1:0] == FLD_THR2 && nvmWrData == wb_dat_i;
  endproperty
  a_nvm_write: assert property (p_nvm_write) else $error("setting not stored");
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h40 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_open_drain;
    doutO == '0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("output driven high");
  property p_open_lamp;
    rdValid && rdOpen ##1 !rdValid [*2] |-> ##1 ledOpen;
  endproperty
  a_open_lamp: assert property (p_open_lamp) else $error("open lamp late");
  property p_ident;
    wb_ack_o && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[0]
      |-> ##[1:LIM] !ledPower;
  endproperty
  a_ident: assert property (p_ident) else $error("power lamp not blinking");
  property p_oe_cause;
    $changed(doutOeN) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(rdValid, 3)
      || $past(rdValid, 4) || $past(nvmRdValid) || $past(nvmRdValid, 2) || $past(nvmRdValid, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("output moved without cause");
  c_open: cover property ($rose(ledOpen));
  c_reload: cover property (wb_ack_o && nLoad_r == 8'h60);
  c_blink: cover property ($fell(ledPower));
endmodule // tcal_alarm_monitor
bind tcal_alarm_top tcal_alarm_monitor #(.BLINK_CYC(BLINK_CYC)) mon_i (.clk, .reset_n, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rdValid, .rdOpen, .nvmRdValid,
  .nvmWrEn, .nvmAddr, .nvmWrData, .doutO, .doutOeN, .ledPower, .ledOpen);
`default_nettype wire

// file: dv/tcal_alarm_top_test.sv
// Self-checking bench for the thermocouple alarm logic
`timescale 1ns/1ps
`default_nettype none
module tcal_alarm_top_test
  import tcal_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, slow = 1'b1;
  logic [7:0] adr = 8'h0, din = 8'ha5;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic rdValid = 1'b0, rdOpen = 1'b0, cm = 1'b0, nvmRdEn, nvmWrEn, nvmRdValid;
  logic [4:0] rdChan = 5'h3;
  logic signed [23:0] rdRaw = 24'sd0, rdCjc = 24'sd5;
  logic [6:0] nvmAddr;
  logic [31:0] nvmWrData, nvmRdData, doutO, doutOeN;
  logic ledPower, ledActivity, ledAlarm, ledOpen;
  int n_mismatch = 0, check_count = 0, fp, fa;
  logic [7:0] cf [10] = '{8'h10, 8'h10, 8'h10, 8'h11, 8'h11, 8'h12, 8'h12, 8'h12, 8'h22, 8'h20};
  int dv [10] = '{100, 70, 40, 100, 101, 40, 70, 101, 100, 40};
  logic sw [10] = '{0, 0, 0, 0, 0, 1, 1, 1, 0, 0};
  logic ex [10] = '{0, 0, 1, 0, 1, 0, 1, 0, 1, 0};
  localparam logic [31:0] FH = 32'h42c80000;
  localparam logic [31:0] FL = 32'h42480000;
  tcal_alarm_top #(.BLINK_CYC(8), .ACT_CYC(4)) tcal_alarm_top_i (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rdValid(rdValid), .rdChan(rdChan),
    .rdRaw(rdRaw), .rdCjc(rdCjc), .rdOpen(rdOpen), .rdCmFault(cm), .nvmRdEn(nvmRdEn),
    .nvmWrEn(nvmWrEn), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .nvmRdData(nvmRdData),
    .nvmRdValid(nvmRdValid), .din(din), .doutO(doutO), .doutOeN(doutOeN),
    .ledPower(ledPower), .ledActivity(ledActivity), .ledAlarm(ledAlarm), .ledOpen(ledOpen));
  tcal_nvm_model tcal_nvm_model_i (.clk(clk), .slow(slow), .nvmRdEn(nvmRdEn),
    .nvmWrEn(nvmWrEn), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .nvmRdData(nvmRdData),
    .nvmRdValid(nvmRdValid));
  initial forever #12.5 clk = ~clk;
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, waits for ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 3000);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // One sample on channel 3 with cold-junction offset 5
  task automatic smp(input int d, input logic [1:0] f);
    @(posedge clk);
    rdValid <= 1'b1;
    rdRaw <= 24'(d + 5);
    rdOpen <= f[0];
    cm <= f[1];
    @(posedge clk);
    rdValid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic falls(input int n);
    logic p, a;
    fp = 0;
    fa = 0;
    p = ledPower;
    a = ledActivity;
    repeat (n)
    begin
      @(posedge clk);
      fp += int'(p && !ledPower);
      fa += int'(a && !ledActivity);
      p = ledPower;
      a = ledActivity;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    wr(ADR_CHSEL, 32'h0);
    slow <= 1'b0;
    rd(ADR_THR1, FH);
    rd(ADR_DIN, 32'ha5);
    rd(8'h80, 32'h0);
    wr(ADR_CHSEL, 32'h3);
    for (int i = 0; i < 10; i++)
    begin
      wr(ADR_THR1, sw[i] ? FL : FH);
      wr(ADR_THR2, sw[i] ? FH : FL);
      wr(ADR_CFG, {24'h0, cf[i]});
      smp(dv[i], 1'b0);
      chk({31'h0, doutOeN[3]}, {31'h0, ex[i]});
      chk({31'h0, ledAlarm}, {31'h0, cf[i][5] ? ex[i] : ~ex[i]});
      chk({31'h0, doutOeN[2]}, 32'h1);
    end
    rd(ADR_READING, 32'h42200000);
    wr(ADR_CFG, 32'h28);
    smp(70, 1'b1);
    chk({31'h0, doutOeN[3]}, 32'h1);
    chk({31'h0, ledOpen}, 32'h1);
    rd(ADR_OPEN, 32'h8);
    smp(200, 1'b0);
    chk({30'h0, doutOeN[3], ledOpen}, 32'h0);
    smp(200, 2'h2);
    chk({31'h0, doutOeN[3]}, 32'h1);
    wr(ADR_CFG, 32'h24);
    smp(100, 1'b0);
    chk({31'h0, doutOeN[3]}, 32'h1);
    wr(ADR_CFG, 32'h50);
    smp(100, 1'b0);
    smp(40, 1'b0);
    chk({31'h0, doutOeN[3]}, 32'h0);
    wr(ADR_CLEAR, 32'h8);
    repeat (3) @(posedge clk);
    chk({31'h0, doutOeN[3]}, 32'h1);
    wr(ADR_CFG, 32'h0);
    wr(ADR_DOUT, 32'hfffffff7);
    repeat (3) @(posedge clk);
    chk({31'h0, doutOeN[3]}, 32'h0);
    wr(ADR_CTRL, 32'h1);
    falls(200);
    chk(fp, 5);
    chk(fa, 1);
    wr(ADR_CTRL, 32'h2);
    falls(64);
    chk({31'h0, fp > 2 && fa > 2}, 32'h1);
    summarize();
  end
endmodule // tcal_alarm_top_test
`default_nettype wire

// file: dv/tcal_nvm_model.sv
// Settings store model answering read and write pulses of the alarm logic
`timescale 1ns/1ps
`default_nettype none
module tcal_nvm_model
  import tcal_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire logic nvmRdEn,
  input wire logic nvmWrEn,
  input wire logic [NVM_AW-1:0] nvmAddr,
  input wire logic [31:0] nvmWrData,
  output logic [31:0] nvmRdData,
  output logic nvmRdValid
);
  logic [31:0] mem [2**NVM_AW];
  logic [NVM_AW-1:0] aHold;
  logic late;
  initial
  begin
    nvmRdValid = 1'b0;
    nvmRdData = 32'h0;
    late = 1'b0;
    foreach (mem[i])
      mem[i] = 32'h0;
    mem[7'h00] = 32'h42c80000;
  end
  // Prompt or one cycle late answer; idle data never repeats
  always @(posedge clk)
  begin
    late <= nvmRdEn;
    aHold <= nvmRdEn ? nvmAddr : aHold;
    nvmRdValid <= slow ? late : nvmRdEn;
    nvmRdData <= (slow ? late : nvmRdEn) ? mem[slow ? aHold : nvmAddr] : ~nvmRdData;
    if (nvmWrEn)
      mem[nvmAddr] <= nvmWrData;
  end
endmodule // tcal_nvm_model
`default_nettype wire
